// file: hdl/ssb_params.svh
`ifndef SSB_PARAMS_SVH
`define SSB_PARAMS_SVH

// Array geometry
`define SSB_ADDR_W 19
`define SSB_LANES 4
`define SSB_LANE_W 8
`define SSB_DEPTH 524288

// Register offsets on the bus
`define SSB_WB_ADR_W 8
`define SSB_OFF_CFG 8'h00
`define SSB_OFF_STAT 8'h04
`define SSB_OFF_ADDR 8'h08

// Config register fields and reset value
`define SSB_CFG_WIDTH_LSB 0
`define SSB_CFG_WIDTH_MSB 1
`define SSB_CFG_WIDTH_RST 2'h2

// Status register fields
`define SSB_STAT_STATE_LSB 0
`define SSB_STAT_COUNT_LSB 2
`define SSB_STAT_MODE_BIT 4

// Lane masks per width option
`define SSB_LANES_TWO 4'h3
`define SSB_LANES_FOUR 4'hf
`define SSB_LANES_NONE 4'h0

`endif

// file: hdl/ssb_pkg.sv
package ssb_pkg;

  // Width option chosen by software
  typedef enum logic [1:0]
  {
    SSB_W18 = 2'b00,
    SSB_W32 = 2'b01,
    SSB_W36 = 2'b10
  } ssb_width_e;

  // Burst state kept between cycles
  typedef enum logic [1:0]
  {
    SSB_ST_DESELECT = 2'b00,
    SSB_ST_READ = 2'b01,
    SSB_ST_WRITE = 2'b10
  } ssb_state_e;

  // One memory word: four byte lanes plus their parity bits
  typedef struct packed
  {
    logic [3:0] parity;
    logic [3:0][7:0] data;
  } ssb_lanes_s;

  // Synchronous pin group, sampled as one
  typedef struct packed
  {
    logic [18:0] sync_address_inputs;
    logic advance_or_load_n;
    logic read_not_write;
    logic chip_en_n;
    logic chip_en2_n;
    logic chip_en2;
    logic [3:0] byte_write_n;
    logic burst_mode;
    ssb_lanes_s lanes;
  } ssb_pins_s;

endpackage

// file: hdl/ssb_burst_ctr.sv
`timescale 1ns/1ns
`include "ssb_params.svh"
module ssb_burst_ctr
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic load_i,
  input wire logic advance_i,
  input wire logic [1:0] start_i,
  input wire logic burst_mode_i,
  // Results
  output logic [1:0] next_low_o,
  output logic [1:0] count_o
);
  import ssb_pkg::*;

  logic [1:0] start_reg;
  logic [1:0] count_reg;
  logic [1:0] count_next;

  // Start bits and step count; two bits so it wraps every fourth step
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_reg <= 2'h0;
      count_reg <= 2'h0;
    end
    else if (load_i)
    begin
      start_reg <= start_i;
      count_reg <= 2'h0;
    end
    else if (advance_i)
    begin
      count_reg <= count_next;
    end
  end

  // Address of the step about to be taken
  always_comb
  begin
    count_next = count_reg + 2'h1;
    if (burst_mode_i)
      next_low_o = start_reg ^ count_next;
    else
      next_low_o = start_reg + count_next;
  end

  assign count_o = count_reg;
endmodule

// file: hdl/ssb_mem.sv
`timescale 1ns/1ns
`include "ssb_params.svh"
module ssb_mem
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Access port
  input wire logic [`SSB_ADDR_W-1:0] addr_i,
  input wire logic [`SSB_LANES-1:0] lane_we_i,
  input wire logic re_i,
  input wire ssb_pkg::ssb_lanes_s wr_data_i,
  output ssb_pkg::ssb_lanes_s rd_data_o
);
  import ssb_pkg::*;

  ssb_lanes_s mem_array [0:`SSB_DEPTH-1];
  ssb_lanes_s rd_data_reg;

  // Byte-lane writes, each lane with its own parity bit
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < `SSB_LANES; i++)
    begin
      if (lane_we_i[i])
      begin
        mem_array[addr_i].data[i] <= wr_data_i.data[i];
        mem_array[addr_i].parity[i] <= wr_data_i.parity[i];
      end
    end
  end

  // Registered read port; holds last word between reads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_reg <= '0;
    else if (re_i)
      rd_data_reg <= mem_array[addr_i];
  end

  assign rd_data_o = rd_data_reg;
endmodule

// file: hdl/ssb_sram.sv
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "ssb_params.svh"
module ssb_sram
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronous address and control pins
  input wire logic [`SSB_ADDR_W-1:0] sync_address_inputs_i,
  input wire logic advance_or_load_n_i,
  input wire logic read_not_write_i,
  input wire logic chip_en_n_i,
  input wire logic chip_en2_n_i,
  input wire logic chip_en2_i,
  input wire logic [`SSB_LANES-1:0] byte_write_n_i,
  input wire logic burst_mode_i,
  // Asynchronous output drive enable
  input wire logic output_drive_n_i,
  // Data and parity lanes, split into in, out and enable
  input wire ssb_pkg::ssb_lanes_s lanes_i,
  output ssb_pkg::ssb_lanes_s lanes_o,
  output logic [`SSB_LANES-1:0] data_oe_n_o,
  output logic [`SSB_LANES-1:0] parity_oe_n_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`SSB_WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import ssb_pkg::*;

  // Data lanes allowed by a width option
  function automatic logic [`SSB_LANES-1:0] lane_mask(input ssb_width_e w);
    if (w == SSB_W18)
      lane_mask = `SSB_LANES_TWO;
    else
      lane_mask = `SSB_LANES_FOUR;
  endfunction

  // Parity lanes that carry data for a width option
  function automatic logic [`SSB_LANES-1:0] parity_mask(input ssb_width_e w);
    case (w)
      SSB_W18: parity_mask = `SSB_LANES_TWO;
      SSB_W36: parity_mask = `SSB_LANES_FOUR;
      default: parity_mask = `SSB_LANES_NONE;
    endcase
  endfunction

  ssb_pins_s pin_raw;
  ssb_pins_s pin_meta_reg;
  ssb_pins_s pin_sync_reg;
  ssb_state_e state_reg;
  ssb_state_e state_next;
  ssb_width_e cfg_width_reg;
  logic [`SSB_ADDR_W-1:2] base_hi_reg;
  logic [`SSB_ADDR_W-1:0] last_addr_reg;
  logic [`SSB_LANES-1:0] drive_reg;
  logic [`SSB_LANES-1:0] parity_drive_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic load_cyc;
  logic selected;
  logic acc_valid;
  logic acc_read;
  logic [`SSB_ADDR_W-1:0] acc_addr;
  logic [`SSB_ADDR_W-1:0] load_addr;
  logic [`SSB_LANES-1:0] mem_we;
  logic [1:0] next_low;
  logic [1:0] burst_count;
  logic wb_req;
  logic [31:0] stat_word;

  // Gather every synchronous pin into one group
  assign pin_raw = '{
    sync_address_inputs: sync_address_inputs_i,
    advance_or_load_n: advance_or_load_n_i,
    read_not_write: read_not_write_i,
    chip_en_n: chip_en_n_i,
    chip_en2_n: chip_en2_n_i,
    chip_en2: chip_en2_i,
    byte_write_n: byte_write_n_i,
    burst_mode: burst_mode_i,
    lanes: lanes_i
  };

  // Two-stage synchroniser; pins are off-chip, so nothing reads stage one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Load versus advance, and the chip-enable decode
  assign load_cyc = ~pin_sync_reg.advance_or_load_n;
  assign selected = ~pin_sync_reg.chip_en_n & ~pin_sync_reg.chip_en2_n &
                    pin_sync_reg.chip_en2;

  // Wide options have half the depth, so the top address bit is dropped
  always_comb
  begin
    load_addr = pin_sync_reg.sync_address_inputs;
    if (cfg_width_reg != SSB_W18)
      load_addr[`SSB_ADDR_W-1] = 1'b0;
  end

  // Decide this cycle's access and the next burst state
  always_comb
  begin
    state_next = state_reg;
    acc_valid = 1'b0;
    acc_read = 1'b0;
    acc_addr = {base_hi_reg, next_low};
    if (load_cyc)
    begin
      acc_addr = load_addr;
      if (selected)
      begin
        acc_valid = 1'b1;
        acc_read = pin_sync_reg.read_not_write;
        if (pin_sync_reg.read_not_write)
          state_next = SSB_ST_READ;
        else
          state_next = SSB_ST_WRITE;
      end
      else
      begin
        state_next = SSB_ST_DESELECT;
      end
    end
    else
    begin
      // Cycle type comes from the state, never from the pin
      case (state_reg)
        SSB_ST_READ:
        begin
          acc_valid = 1'b1;
          acc_read = 1'b1;
        end
        SSB_ST_WRITE:
        begin
          acc_valid = 1'b1;
          acc_read = 1'b0;
        end
        SSB_ST_DESELECT:
        begin
          acc_valid = 1'b0;
        end
        default:
        begin
          state_next = SSB_ST_DESELECT;
        end
      endcase
    end
  end

  // Burst state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= SSB_ST_DESELECT;
    else
      state_reg <= state_next;
  end

  // Upper address bits stay as loaded for the whole burst
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      base_hi_reg <= '0;
    else if (load_cyc && selected)
      base_hi_reg <= load_addr[`SSB_ADDR_W-1:2];
  end

  // Low-bit burst counter
  ssb_burst_ctr u_burst_ctr
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load_cyc && selected),
    .advance_i(!load_cyc && (state_reg != SSB_ST_DESELECT)),
    .start_i(load_addr[1:0]),
    .burst_mode_i(pin_sync_reg.burst_mode),
    .next_low_o(next_low),
    .count_o(burst_count)
  );

  // Byte writes only on lanes that exist in this width option
  always_comb
  begin
    mem_we = `SSB_LANES_NONE;
    if (acc_valid && !acc_read)
      mem_we = ~pin_sync_reg.byte_write_n & lane_mask(cfg_width_reg);
  end

  // Storage with registered read data
  ssb_mem u_mem
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(acc_addr),
    .lane_we_i(mem_we),
    .re_i(acc_valid && acc_read),
    .wr_data_i(pin_sync_reg.lanes),
    .rd_data_o(lanes_o)
  );

  // Lane drive is set on the same edge as the read data, in step with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      drive_reg <= `SSB_LANES_NONE;
      parity_drive_reg <= `SSB_LANES_NONE;
    end
    else if (acc_valid && acc_read)
    begin
      drive_reg <= lane_mask(cfg_width_reg);
      parity_drive_reg <= parity_mask(cfg_width_reg);
    end
    else
    begin
      drive_reg <= `SSB_LANES_NONE;
      parity_drive_reg <= `SSB_LANES_NONE;
    end
  end

  // Drive pin acts with no clock, so it bypasses the flops on purpose
  assign data_oe_n_o = ~drive_reg | {`SSB_LANES{output_drive_n_i}};
  assign parity_oe_n_o = ~parity_drive_reg | {`SSB_LANES{output_drive_n_i}};

  // Last accessed address, for software to watch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      last_addr_reg <= '0;
    else if (acc_valid)
      last_addr_reg <= acc_addr;
  end

  // Bus request seen once; ack drops the cycle after it rises
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_reg;

  // Width option register; the unused code is refused
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_width_reg <= ssb_width_e'(`SSB_CFG_WIDTH_RST);
    else if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `SSB_OFF_CFG) &&
             (wb_dat_i[`SSB_CFG_WIDTH_MSB:`SSB_CFG_WIDTH_LSB] != 2'h3))
      cfg_width_reg <= ssb_width_e'(wb_dat_i[`SSB_CFG_WIDTH_MSB:`SSB_CFG_WIDTH_LSB]);
  end

  // Status word: burst state, step count and mode pin
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`SSB_STAT_STATE_LSB +: 2] = state_reg;
    stat_word[`SSB_STAT_COUNT_LSB +: 2] = burst_count;
    stat_word[`SSB_STAT_MODE_BIT] = pin_sync_reg.burst_mode;
  end

  // Ack and read data; unmapped offsets ack with zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_reg <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `SSB_OFF_CFG: wb_dat_reg <= {30'h0000_0000, cfg_width_reg};
          `SSB_OFF_STAT: wb_dat_reg <= stat_word;
          `SSB_OFF_ADDR: wb_dat_reg <= {13'h0000, last_addr_reg};
          default: wb_dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
endmodule

// file: test/ssb_sram_chk.sv
`timescale 1ns/1ns
module ssb_sram_chk
  import ssb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin controls
  input wire logic advance_or_load_n_i,
  input wire logic read_not_write_i,
  input wire logic chip_en_n_i,
  input wire logic chip_en2_n_i,
  input wire logic chip_en2_i,
  input wire logic output_drive_n_i,
  input wire logic [3:0] data_oe_n_o,
  input wire logic [3:0] parity_oe_n_o,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] width_reg;
  logic sel;
  logic rd_ld;
  logic all_off;
  // Decoded pin cycles
  assign sel = !chip_en_n_i && !chip_en2_n_i && chip_en2_i;
  assign rd_ld = !advance_or_load_n_i && read_not_write_i && sel;
  assign all_off = &data_oe_n_o && &parity_oe_n_o;
  // Width as software last set it; value 3 is refused
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      width_reg <= 2'h2;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00
             && wb_sel_i[0] && wb_dat_i[1:0] != 2'h3)
      width_reg <= wb_dat_i[1:0];
  end
  // Read load then three advances, drivers allowed
  sequence s_rd;
    (rd_ld && !output_drive_n_i) ##1 (advance_or_load_n_i && !output_drive_n_i)[*3];
  endsequence
  // Non-read cycle, write load, two advances
  sequence s_wr;
    (!advance_or_load_n_i && !rd_ld) ##1 (!advance_or_load_n_i && !read_not_write_i && sel)
      ##1 advance_or_load_n_i[*2];
  endsequence
  property p_oe_async;
    output_drive_n_i |-> all_off;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("drivers on while gated");
  property p_x18;
    (width_reg == SSB_W18) |-> data_oe_n_o[3:2] == 2'h3 && parity_oe_n_o[3:2] == 2'h3;
  endproperty
  a_x18: assert property (p_x18) else $error("upper lanes driven in x18");
  property p_x32;
    (width_reg == SSB_W32) |-> &parity_oe_n_o;
  endproperty
  a_x32: assert property (p_x32) else $error("parity driven in x32");
  property p_parity_pair;
    (width_reg == SSB_W36) |-> parity_oe_n_o == data_oe_n_o;
  endproperty
  a_parity_pair: assert property (p_parity_pair) else $error("parity apart from lane");
  property p_rd;
    s_rd |-> data_oe_n_o == ((width_reg == SSB_W18) ? 4'hc : 4'h0);
  endproperty
  a_rd: assert property (p_rd) else $error("read burst not driven");
  property p_wr;
    s_wr |-> all_off ##1 all_off;
  endproperty
  a_wr: assert property (p_wr) else $error("write burst drove lanes");
  property p_desel;
    (!advance_or_load_n_i && !sel) ##1 advance_or_load_n_i[*3] |-> all_off;
  endproperty
  a_desel: assert property (p_desel) else $error("deselected device drove");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer out of step");
endmodule

// file: test/ssb_ctl_model.sv
`timescale 1ns/1ns
module ssb_ctl_model
  import ssb_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Device side of the lanes
  input wire ssb_pkg::ssb_lanes_s dev_lanes_i,
  input wire logic [3:0] data_oe_n_i,
  input wire logic [3:0] parity_oe_n_i,
  // Pins and resolved lanes
  output ssb_pkg::ssb_pins_s pins_o,
  output ssb_pkg::ssb_lanes_s bus_o
);
  logic [35:0] dev_on;
  logic ctl_on = 1'b0;
  // Released lanes float to the inverse, so stale data never matches
  assign dev_on = ~{parity_oe_n_i, {8{data_oe_n_i[3]}}, {8{data_oe_n_i[2]}},
                    {8{data_oe_n_i[1]}}, {8{data_oe_n_i[0]}}};
  assign bus_o = (dev_on & dev_lanes_i) | (~dev_on & (ctl_on ? pins_o.lanes : ~pins_o.lanes));
  // Start deselected with a load cycle
  initial
  begin
    pins_o = '0;
    pins_o.chip_en_n = 1'b1;
  end
  // One pin cycle, launched just after a rising edge
  task automatic step(input logic adv, input logic rnw, input logic en,
                      input logic [18:0] a, input logic [3:0] bw_n, input ssb_lanes_s d);
    @(posedge clk_i);
    pins_o.advance_or_load_n <= adv;
    pins_o.read_not_write <= rnw;
    pins_o.chip_en_n <= !en;
    pins_o.chip_en2_n <= !en;
    pins_o.chip_en2 <= en;
    pins_o.sync_address_inputs <= a;
    pins_o.byte_write_n <= bw_n;
    pins_o.lanes <= d;
    ctl_on <= (bw_n != 4'hf);
  endtask
  // Called only while the device is held in reset
  task automatic set_mode(input logic m);
    pins_o.burst_mode <= m;
  endtask
endmodule

// file: test/ssb_sram_tb_top.sv
`timescale 1ns/1ns
module ssb_sram_tb_top;
  import ssb_pkg::*;
  localparam logic [18:0] BASE = 19'h2_5678;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] dat;
  logic ack;
  logic drive_n = 1'b0;
  logic [3:0] doe_n;
  logic [3:0] poe_n;
  ssb_pins_s pins;
  ssb_lanes_s bus;
  ssb_lanes_s dout;
  int bad_count = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  ssb_sram dut (.clk_i(clk_i), .rst_i(rst_i),
    .sync_address_inputs_i(pins.sync_address_inputs),
    .advance_or_load_n_i(pins.advance_or_load_n), .read_not_write_i(pins.read_not_write),
    .chip_en_n_i(pins.chip_en_n), .chip_en2_n_i(pins.chip_en2_n), .chip_en2_i(pins.chip_en2),
    .byte_write_n_i(pins.byte_write_n), .burst_mode_i(pins.burst_mode),
    .output_drive_n_i(drive_n), .lanes_i(bus), .lanes_o(dout), .data_oe_n_o(doe_n),
    .parity_oe_n_o(poe_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack));
  ssb_ctl_model ctl (.clk_i(clk_i), .dev_lanes_i(dout), .data_oe_n_i(doe_n),
    .parity_oe_n_i(poe_n), .pins_o(pins), .bus_o(bus));
  // Stored pattern; address low nibble lands in the parity bits
  function automatic ssb_lanes_s word(input logic [18:0] a);
    return {a[3:0], {4{a[7:0]}}};
  endfunction
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Classic single cycle; held until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 64);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 64)
    begin
      bad_count++;
      conclude();
    end
  endtask
  // Write burst from low bits 00; address pins ignored while advancing
  task automatic wr_burst();
    ctl.step(1'b0, 1'b0, 1'b1, BASE, 4'h0, word(BASE));
    for (int i = 1; i < 4; i++)
      ctl.step(1'b1, 1'b1, 1'b1, 19'h0, 4'h0, word(BASE + 19'(i)));
    for (int i = 0; i < 4; i++)
      ctl.step(i == 0 ? 1'b0 : 1'b1, 1'b1, 1'b0, 19'h0, 4'hf, '0);
  endtask
  // Read burst, enables off and write asked while advancing; collects driven words
  task automatic rd(input logic [1:0] st, input int n, input logic gate, output ssb_lanes_s q[$]);
    q = {};
    @(posedge clk_i);
    drive_n <= gate;
    fork
      begin
        ctl.step(1'b0, 1'b1, 1'b1, {BASE[18:2], st}, 4'hf, '0);
        for (int i = 1; i < n; i++)
          ctl.step(1'b1, 1'b0, 1'b0, 19'h0, 4'hf, '0);
        ctl.step(1'b0, 1'b1, 1'b0, 19'h0, 4'hf, '0);
      end
      repeat (n + 8)
      begin
        @(posedge clk_i);
        #1;
        if (doe_n[0] === 1'b0)
          q.push_back(dout);
      end
    join
    // Release the gate on an edge of its own, never in the collector's step
    @(posedge clk_i);
    drive_n <= 1'b0;
  endtask
  task automatic t_burst(input logic m);
    ssb_lanes_s q[$];
    logic [1:0] lo;
    rd(2'h1, 5, 1'b0, q);
    chk("burst length", 36'h5, 36'(q.size()));
    foreach (q[i])
    begin
      lo = m ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
      chk("burst word", word({BASE[18:2], lo}), q[i]);
    end
    rd(2'h1, 5, 1'b1, q);
    chk("gated words", 36'h0, 36'(q.size()));
    $display("burst test done, mode %0d", m);
  endtask
  task automatic t_width();
    ssb_lanes_s q[$];
    logic [35:0] mk;
    for (int w = 0; w < 3; w++)
    begin
      wb(1'b1, 8'h00, 32'(w));
      wb(1'b0, 8'h00, 32'h0);
      chk("width field", 36'(w), 36'(rdat[1:0]));
      mk = (w == 0) ? 36'h3_0000_ffff : (w == 1) ? 36'h0_ffff_ffff : 36'hf_ffff_ffff;
      rd(2'h0, 4, 1'b0, q);
      chk("lane count", 36'h4, 36'(q.size()));
      foreach (q[i])
        chk("lane word", word(BASE + 19'(i)) & mk, q[i] & mk);
    end
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b1, 8'h40, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk("width kept", 36'h2, 36'(rdat[1:0]));
    wb(1'b0, 8'h04, 32'h0);
    chk("mode bit", 36'(pins.burst_mode), 36'(rdat[4]));
    // Deselected after a four-word burst: state idle, three steps counted
    chk("status word", 36'h0_0000_000c, 36'(rdat));
    wb(1'b0, 8'h08, 32'h0);
    chk("last address", 36'h0_0002_567b, 36'(rdat));
    $display("width test done");
  endtask
  // Mode changes only under reset; memory rewritten after each
  initial
  begin
    for (int m = 0; m < 2; m++)
    begin
      rst_i <= 1'b1;
      ctl.set_mode(m[0]);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      wr_burst();
      t_burst(m[0]);
      if (m == 0)
        t_width();
    end
    conclude();
  end
endmodule
bind ssb_sram ssb_sram_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .advance_or_load_n_i(advance_or_load_n_i), .read_not_write_i(read_not_write_i),
  .chip_en_n_i(chip_en_n_i), .chip_en2_n_i(chip_en2_n_i), .chip_en2_i(chip_en2_i),
  .output_drive_n_i(output_drive_n_i), .data_oe_n_o(data_oe_n_o),
  .parity_oe_n_o(parity_oe_n_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o));
